// >>> rtl/bdr_top.sv
// Bus D register: edge-captured storage bank with three-state outputs and APB access.
// Assumes pins come from another domain and are synchronised; APB runs on core_clk.
// Notes on behaviour
// - Parity-width variant holds nine captured bits with clear and load gate.
// - Wide variant holds ten captured bits; no clear, no load gate.
// - Byte-width variant holds eight captured bits with clear and load gate.
// - One capture clock and one output gate are shared by every bit.
// - Rising capture edge stores each data input when clear inactive, gate open.
// - Outputs are true three-state; driven level equals last captured value.
// - Output gate low drives the stored bits onto the outputs.
// - Output gate high floats every output.
// - Output gate never changes storage; loading and clearing continue while floating.
// - Clear low forces all bits to zero; enabled outputs then read low.
// - Capture edges are ignored while clear is held low.
// - Load gate low lets each rising edge transfer data into storage.
// - Load gate high keeps storage unchanged whatever clock or data do.
//
// The APB slave port and the register offsets were decided locally.
module bdr_top #(
  parameter logic [1:0] VARIANT = bdr_pkg::VAR_PARITY
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Device pins
  input wire logic capture_clock,
  input wire logic out_gate_n,
  input wire logic clear_n,
  input wire logic load_gate_n,
  input wire logic [bdr_pkg::MAX_WIDTH-1:0] d_pin,
  // Bus outputs, three-state as value plus enable
  output logic [bdr_pkg::MAX_WIDTH-1:0] q_out,
  output logic [bdr_pkg::MAX_WIDTH-1:0] q_oe
);
  localparam int W = (VARIANT == bdr_pkg::VAR_WIDE) ? bdr_pkg::WIDTH_WIDE :
                     (VARIANT == bdr_pkg::VAR_BYTE) ? bdr_pkg::WIDTH_BYTE :
                     bdr_pkg::WIDTH_PARITY;
  localparam bit HAS_CTRL = (VARIANT != bdr_pkg::VAR_WIDE);
  localparam int NPIN = bdr_pkg::MAX_WIDTH + 4;

  typedef struct packed {
    logic [4:0] ctrl;
    logic [bdr_pkg::MAX_WIDTH-1:0] data_in;
    logic cap_prev;
    logic [31:0] rdata;
    logic [bdr_pkg::MAX_WIDTH-1:0] q;
    logic [bdr_pkg::MAX_WIDTH-1:0] oe;
  } bdr_top_s;

  bdr_top_s st_r;
  bdr_top_s st_nxt;
  logic [NPIN-1:0] pin_async;
  logic [NPIN-1:0] pin_sync;
  logic s_cap;
  logic s_oe_n;
  logic s_clr_n;
  logic s_ld_n;
  logic [bdr_pkg::MAX_WIDTH-1:0] s_d;
  logic use_pins;
  logic eff_cap;
  logic eff_oe_n;
  logic eff_clr_n;
  logic eff_ld_n;
  logic [W-1:0] eff_d;
  logic cap_edge;
  logic sw_cap;
  logic [W-1:0] stored;
  logic wr_en;
  logic rd_en;

  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a == bdr_pkg::ADDR_CTRL) || (a == bdr_pkg::ADDR_DATA_IN) ||
                 (a == bdr_pkg::ADDR_STORED) || (a == bdr_pkg::ADDR_STATUS) ||
                 (a == bdr_pkg::ADDR_PIN);
  endfunction

  assign pin_async = {capture_clock, out_gate_n, clear_n, load_gate_n, d_pin};

  bdr_sync #(
    .W(NPIN)
  ) u_sync (
    .core_clk(core_clk),
    .resetn(resetn),
    .async_in(pin_async),
    .sync_out(pin_sync)
  );

  assign {s_cap, s_oe_n, s_clr_n, s_ld_n, s_d} = pin_sync;

  // Software may take over the pins; the choice is one bit so the bank sees one source
  assign use_pins = st_r.ctrl[bdr_pkg::CTRL_USE_PINS];
  assign sw_cap = wr_en && (paddr == bdr_pkg::ADDR_CTRL) && pwdata[bdr_pkg::CTRL_CAPTURE];
  assign eff_cap = use_pins ? s_cap : 1'b0;
  assign eff_oe_n = use_pins ? s_oe_n : st_r.ctrl[bdr_pkg::CTRL_OUT_GATE_N];
  assign eff_clr_n = use_pins ? s_clr_n : st_r.ctrl[bdr_pkg::CTRL_CLEAR_N];
  assign eff_ld_n = use_pins ? s_ld_n : st_r.ctrl[bdr_pkg::CTRL_LOAD_GATE_N];
  assign eff_d = use_pins ? s_d[W-1:0] : st_r.data_in[W-1:0];

  // One shared rising-edge detector feeds every bit
  assign cap_edge = (use_pins && eff_cap && !st_r.cap_prev) || (!use_pins && sw_cap);

  bdr_bank #(
    .W(W),
    .HAS_CTRL(HAS_CTRL)
  ) u_bank (
    .core_clk(core_clk),
    .resetn(resetn),
    .capture_pulse(cap_edge),
    .clear_n(eff_clr_n),
    .load_gate_n(eff_ld_n),
    .d_in(eff_d),
    .q(stored)
  );

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;

  always_comb
  begin
    st_nxt = st_r;
    // History follows the pin in both modes, so a pin resting high at hand-over is no edge
    st_nxt.cap_prev = s_cap;
    if (wr_en && (paddr == bdr_pkg::ADDR_CTRL))
    begin
      st_nxt.ctrl = pwdata[4:0];
      st_nxt.ctrl[bdr_pkg::CTRL_CAPTURE] = 1'b0;
    end
    if (wr_en && (paddr == bdr_pkg::ADDR_DATA_IN))
      st_nxt.data_in = pwdata[bdr_pkg::MAX_WIDTH-1:0];
    // Output gate only steers the drivers, never the bank
    st_nxt.q = '0;
    st_nxt.q[W-1:0] = stored;
    st_nxt.oe = '0;
    if (!eff_oe_n)
      st_nxt.oe[W-1:0] = '1;
    else
      st_nxt.oe = '0;
    if (rd_en)
    begin
      st_nxt.rdata = '0;
      case (paddr)
        bdr_pkg::ADDR_CTRL: st_nxt.rdata[4:0] = st_r.ctrl;
        bdr_pkg::ADDR_DATA_IN: st_nxt.rdata[bdr_pkg::MAX_WIDTH-1:0] = st_r.data_in;
        bdr_pkg::ADDR_STORED: st_nxt.rdata[W-1:0] = stored;
        bdr_pkg::ADDR_STATUS:
        begin
          st_nxt.rdata[bdr_pkg::STAT_DRIVING] = !eff_oe_n;
          st_nxt.rdata[bdr_pkg::STAT_CLEARING] = HAS_CTRL && !eff_clr_n;
          st_nxt.rdata[bdr_pkg::STAT_VARIANT +: 2] = VARIANT;
        end
        bdr_pkg::ADDR_PIN: st_nxt.rdata[NPIN-1:0] = pin_sync;
        default: st_nxt.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_r.ctrl <= bdr_pkg::CTRL_RESET;
      st_r.data_in <= '0;
      st_r.cap_prev <= 1'b0;
      st_r.rdata <= '0;
      st_r.q <= bdr_pkg::STORED_RESET;
      st_r.oe <= '0;
    end
    else
      st_r <= st_nxt;
  end

  // Data out of flops; one wait-free access phase per transfer
  assign prdata = st_r.rdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_known(paddr);
  assign q_out = st_r.q;
  assign q_oe = st_r.oe;
endmodule

// >>> shared/bdr_pkg.sv
// Package: variant codes, register map, field positions and reset values for the bus D register.
// Assumes a 32-bit APB slave with one aligned word per register.
package bdr_pkg;
  // Variant codes
  localparam logic [1:0] VAR_PARITY = 2'h0;
  localparam logic [1:0] VAR_WIDE = 2'h1;
  localparam logic [1:0] VAR_BYTE = 2'h2;
  localparam int WIDTH_PARITY = 9;
  localparam int WIDTH_WIDE = 10;
  localparam int WIDTH_BYTE = 8;
  localparam int MAX_WIDTH = 10;
  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DATA_IN = 8'h04;
  localparam logic [7:0] ADDR_STORED = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_PIN = 8'h10;
  // Control field positions
  localparam int CTRL_OUT_GATE_N = 0;
  localparam int CTRL_CLEAR_N = 1;
  localparam int CTRL_LOAD_GATE_N = 2;
  localparam int CTRL_CAPTURE = 3;
  localparam int CTRL_USE_PINS = 4;
  // Status field positions
  localparam int STAT_DRIVING = 0;
  localparam int STAT_CLEARING = 1;
  localparam int STAT_VARIANT = 2;
  // Reset values: outputs driven, clear inactive, load gate closed, software source
  localparam logic [4:0] CTRL_RESET = 5'h06;
  localparam logic [9:0] STORED_RESET = 10'h000;
endpackage

// >>> rtl/bdr_sync.sv
// Two-flop synchroniser for a group of pin levels.
// Assumes the inputs are asynchronous to core_clk; only the second stage is read outside.
module bdr_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } bdr_sync_s;

  bdr_sync_s st_r;
  bdr_sync_s st_nxt;

  always_comb
  begin
    st_nxt.meta = async_in;
    st_nxt.stable = st_r.meta;
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign sync_out = st_r.stable;
endmodule

// >>> rtl/bdr_bank.sv
// Storage bank: one D bit per lane with shared capture enable, clear and load gate.
// Assumes capture_pulse is a one-cycle enable marking a rising capture-clock edge.
module bdr_bank #(
  parameter int W = 8,
  parameter bit HAS_CTRL = 1'b1
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Controls
  input wire logic capture_pulse,
  input wire logic clear_n,
  input wire logic load_gate_n,
  // Data
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] bits;
  } bdr_bank_s;

  bdr_bank_s st_r;
  bdr_bank_s st_nxt;
  logic clr_act;
  logic load_ok;

  // The wide variant has no clear and no load gate, so both are ignored there
  assign clr_act = HAS_CTRL && !clear_n;
  assign load_ok = !HAS_CTRL || !load_gate_n;

  always_comb
  begin
    st_nxt = st_r;
    for (int i = 0; i < W; i++)
    begin
      if (clr_act)
        st_nxt.bits[i] = 1'b0;
      else if (capture_pulse && load_ok)
        st_nxt.bits[i] = d_in[i];
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign q = st_r.bits;
endmodule

// >>> tb/bdr_chk.sv
// Port checker for the parity-width bus D register.
// Assumes pin controls rule once software sets the pin-source bit.
module bdr_chk (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  // Pins
  input wire logic capture_clock,
  input wire logic out_gate_n,
  input wire logic clear_n,
  input wire logic load_gate_n,
  input wire logic [9:0] d_pin,
  input wire logic [9:0] q_out,
  input wire logic [9:0] q_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic pin_r;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // Pin timing only holds once the source bit is known to be set
  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn)
      pin_r <= 1'b0;
    else if (psel && penable && pwrite && paddr == 8'h00)
      pin_r <= pwdata[4];
  upper_lane_a: assert property (q_out[9] == 1'b0 && q_oe[9] == 1'b0)
    else $error("upper lane active");
  shared_gate_a: assert property (q_oe == 10'h000 || q_oe == 10'h1ff)
    else $error("lanes gated apart");
  float_gate_a: assert property ((pin_r && out_gate_n)[*5] |-> q_oe == 10'h000)
    else $error("outputs not floating");
  drive_gate_a: assert property ((pin_r && !out_gate_n)[*5] |-> q_oe == 10'h1ff)
    else $error("outputs not driven");
  clear_zero_a: assert property ((pin_r && !clear_n)[*6] |-> q_out == 10'h000)
    else $error("clear left bits set");
  capture_a: assert property (pin_r && $rose(capture_clock) && clear_n && !load_gate_n
    ##1 (clear_n && !load_gate_n && $stable(d_pin))[*4]
    |-> ##[0:1] q_out[8:0] == d_pin[8:0])
    else $error("edge did not capture");
  load_hold_a: assert property ((pin_r && clear_n && load_gate_n)[*7] |-> $stable(q_out))
    else $error("closed gate changed bits");
  idle_hold_a: assert property ((pin_r && clear_n && !$rose(capture_clock))[*7]
    |-> $stable(q_out))
    else $error("bits moved without edge");
endmodule
bind bdr_top bdr_chk u_chk (.core_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .capture_clock, .out_gate_n, .clear_n, .load_gate_n, .d_pin, .q_out, .q_oe);

// >>> tb/bdr_far.sv
// Far-side bus logic: drives the data and control pins of the register.
// Assumes the bench calls its tasks; pins move just after core_clk rises.
module bdr_far (
  // Clock
  input wire logic core_clk,
  // Pins
  output logic capture_clock,
  output logic out_gate_n,
  output logic clear_n,
  output logic load_gate_n,
  output logic [9:0] d_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    capture_clock = 1'b0;
    out_gate_n = 1'b1;
    clear_n = 1'b1;
    load_gate_n = 1'b0;
    d_pin = 10'h000;
  end
  task ctl(input logic g, input logic c, input logic l);
    @(posedge core_clk);
    out_gate_n <= g;
    clear_n <= c;
    load_gate_n <= l;
    repeat (8) @(posedge core_clk);
  endtask
  // Clock stands low outside a pulse; hi sets how many core cycles it stays high
  task pulse(input logic [9:0] d, input int hi);
    @(posedge core_clk);
    d_pin <= d;
    @(posedge core_clk);
    capture_clock <= 1'b1;
    repeat (hi) @(posedge core_clk);
    capture_clock <= 1'b0;
    repeat (8) @(posedge core_clk);
  endtask
endmodule

// >>> tb/tb.sv
// Bench for the parity-width register: APB master, pin partner, read scoreboard.
// Assumes zero-wait APB and pin-mode latencies of a few core cycles.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, capture_clock, out_gate_n, clear_n, load_gate_n;
  logic [9:0] d_pin, q_out, q_oe, v, w;
  logic [31:0] expq[$];
  logic [31:0] mskq[$];
  logic errq[$];
  int n_errors = 0;
  int comparisons = 0;
  int seed = 32'h6f99;
  always #5 core_clk = ~core_clk;
  bdr_top u_bdr_top (.core_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .capture_clock, .out_gate_n, .clear_n, .load_gate_n, .d_pin,
    .q_out, .q_oe);
  bdr_far u_bdr_far (.core_clk, .capture_clock, .out_gate_n, .clear_n, .load_gate_n, .d_pin);
  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD %0t read %h expected %h", $time, seen, exp);
    end
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input logic x = 1'b0);
    expq.push_back(e);
    mskq.push_back(m);
    errq.push_back(x);
    apb(1'b0, a, 32'h0);
  endtask
  // Read data is taken at the completing edge only
  always @(posedge core_clk)
    if (psel && penable && !pwrite && pready === 1'b1)
    begin
      check(prdata & mskq.pop_front(), expq.pop_front());
      check(32'(pslverr), 32'(errq.pop_front()));
    end
  task tally_and_finish;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    #50000;
    n_errors++;
    tally_and_finish();
  end
  initial
  begin
    repeat (20) @(posedge core_clk);
    resetn <= 1'b1;
    rd(8'h00, 32'h06, 32'h1f);
    rd(8'h0c, 32'h0, 32'hc);
    rd(8'h20, 32'h0, 32'hffffffff, 1'b1);
    v = 10'($random(seed));
    apb(1'b1, 8'h04, 32'(v));
    apb(1'b1, 8'h00, 32'h02);
    apb(1'b1, 8'h00, 32'h0a);
    rd(8'h08, 32'(v[8:0]), 32'hffffffff);
    w = 10'($random(seed));
    apb(1'b1, 8'h04, 32'(w));
    apb(1'b1, 8'h00, 32'h06);
    apb(1'b1, 8'h00, 32'h0e);
    rd(8'h08, 32'(v[8:0]), 32'hffffffff);
    apb(1'b1, 8'h00, 32'h10);
    for (int i = 0; i < 4; i++)
    begin
      v = 10'($random(seed));
      u_bdr_far.ctl(1'(i), 1'b1, 1'b0);
      u_bdr_far.pulse(v, 1 + i * 3);
      rd(8'h08, 32'(v[8:0]), 32'hffffffff);
    end
    u_bdr_far.ctl(1'b0, 1'b1, 1'b1);
    u_bdr_far.pulse(w, 2);
    rd(8'h08, 32'(v[8:0]), 32'hffffffff);
    u_bdr_far.ctl(1'b0, 1'b0, 1'b0);
    u_bdr_far.pulse(w, 2);
    rd(8'h08, 32'h0, 32'hffffffff);
    u_bdr_far.ctl(1'b0, 1'b1, 1'b0);
    u_bdr_far.pulse(w, 2);
    rd(8'h08, 32'(w[8:0]), 32'hffffffff);
    resetn <= 1'b0;
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    rd(8'h08, 32'h0, 32'hffffffff);
    // Let the scoreboard take the last answer before the verdict
    repeat (2) @(posedge core_clk);
    check(32'(expq.size()), 32'h0);
    tally_and_finish();
  end
endmodule
